// ### design/tipc_edge_filter.sv
// Purpose: Two-sample noise filter and edge selector for one timer input.
// Assumes: Pin is synchronous to pclk; samples only on count ticks.
// Notes: Level starts low, so a pin held high at start reads as a rise.
`timescale 1ns/100ps
`default_nettype none
module tipc_edge_filter
    import tipc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tick,
    input wire logic pin,
    input wire tipc_edge_t edge_sel,
    output logic valid_edge
);
    tipc_filt_t q;
    tipc_filt_t d;

    always_comb
    begin
        d = q;
        d.valid_edge = 1'b0;
        if (tick)
        begin
            d.s0 = pin;
            d.s1 = q.s0;
            // Two equal samples before the level is believed
            if (q.s0 == q.s1 && q.s1 != q.level)
            begin
                d.level = q.s1;
                case (edge_sel)
                    TIPC_FALL: d.valid_edge = ~q.s1;
                    TIPC_RISE: d.valid_edge = q.s1;
                    TIPC_BOTH: d.valid_edge = 1'b1;
                    default: d.valid_edge = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= FILT_RST;
        else if (ce)
            q <= d;
    end

    assign valid_edge = q.valid_edge;

    two_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(q.valid_edge) |-> $past(q.s0) == $past(q.s1))
        else $error("edge taken without two equal samples");
    bad_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && edge_sel == TIPC_BAD) |=> !q.valid_edge)
        else $error("edge reported for prohibited select");
endmodule
`default_nettype wire

// ### design/tipc_pkg.sv
// Purpose: Shared constants and types of the interval/PPG/capture timer.
// Assumes: APB slave, 32-bit data, byte offsets below, 8-bit address.
// Notes: Mode codes are the Gray-ordered state codes of the timer.
package tipc_pkg;
    localparam int CNT_W = 16;
    localparam int PRE_MID_LOG = 2;
    localparam int PRE_SLOW_LOG = 8;

    localparam logic [7:0] OFF_DIR = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_PRESCALE = 8'h08;
    localparam logic [7:0] OFF_OUTCTL = 8'h0C;
    localparam logic [7:0] OFF_CMP0 = 8'h10;
    localparam logic [7:0] OFF_CMP1 = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;
    localparam logic [7:0] OFF_MASK = 8'h20;
    localparam logic [7:0] OFF_LATCH = 8'h24;

    localparam int MODE_RESTART_BIT = 2;
    localparam int TOGGLE_EN_BIT = 4;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_MATCH_BIT = 1;
    localparam int STAT_CAP_BIT = 2;
    localparam int EDGE_FIRST_POS = 4;
    localparam int EDGE_SECOND_POS = 6;
    localparam int PIN_EDGE_FIRST = 0;
    localparam int PIN_PULSE = 1;

    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        TIPC_STOP = 2'b00,
        TIPC_INTERVAL = 2'b01,
        TIPC_PPG = 2'b11,
        TIPC_MEASURE = 2'b10
    } tipc_mode_t;

    typedef enum logic [1:0] {
        TIPC_FALL = 2'b00,
        TIPC_RISE = 2'b01,
        TIPC_BAD = 2'b10,
        TIPC_BOTH = 2'b11
    } tipc_edge_t;

    typedef enum logic [1:0] {
        TIPC_DIV1 = 2'b00,
        TIPC_DIVMID = 2'b01,
        TIPC_DIVSLOW = 2'b10,
        TIPC_DIVOFF = 2'b11
    } tipc_clksel_t;

    typedef struct packed {
        logic s0;
        logic s1;
        logic level;
        logic valid_edge;
    } tipc_filt_t;

    localparam tipc_filt_t FILT_RST = '0;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] latch;
        tipc_mode_t mode;
        logic restart;
        tipc_clksel_t clk_sel;
        logic [1:0][1:0] edge_sel;
        logic toggle_en;
        logic [1:0] mask;
        logic [15:0] cmp0;
        logic [15:0] cmp1;
        logic [15:0] cnt;
        logic running;
        logic pulse;
        logic ovf;
        logic match_f;
        logic cap_f;
        logic match_irq;
        logic cap_irq;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tipc_state_t;

    localparam tipc_state_t ST_RST = '{dir: DIR_RST, mode: TIPC_STOP,
        clk_sel: TIPC_DIV1, default: '0};
endpackage

// ### design/tipc_prescale.sv
// Purpose: Count clock tick generator for the timer.
// Assumes: One pclk domain; ce freezes the divider.
// Notes: The code 11 (external edge clock) gives no tick here.
`timescale 1ns/100ps
`default_nettype none
module tipc_prescale
    import tipc_pkg::*;
#(
    parameter int MID_LOG = PRE_MID_LOG,
    parameter int SLOW_LOG = PRE_SLOW_LOG
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire tipc_clksel_t sel,
    output logic tick
);
    typedef struct packed {
        logic [SLOW_LOG-1:0] cnt;
        logic tick;
    } tipc_pre_t;

    tipc_pre_t q;
    tipc_pre_t d;

    // Refuse divider widths that would leave the mid rate without a tick
    if (MID_LOG < 1 || SLOW_LOG <= MID_LOG)
    begin : g_bad_div
        $error("tipc_prescale: bad divider widths");
    end

    always_comb
    begin
        d = q;
        d.cnt = SLOW_LOG'(q.cnt + 1'b1);
        case (sel)
            TIPC_DIV1: d.tick = 1'b1;
            TIPC_DIVMID: d.tick = &q.cnt[MID_LOG-1:0];
            TIPC_DIVSLOW: d.tick = &q.cnt;
            default: d.tick = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else if (ce)
            q <= d;
    end

    assign tick = q.tick;

    mid_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && sel == TIPC_DIVMID && $stable(sel) && q.tick) |->
        (q.cnt[MID_LOG-1:0] == '0))
        else $error("mid divider tick out of phase");
endmodule
`default_nettype wire

// ### design/tipc_top.sv
// Purpose: 16-bit interval timer, pulse generator and width capture.
// Assumes: APB slave on pclk; port pins synchronous to pclk.
// Notes: Pin 0 is the first edge input, pin 1 pulse out / second input.
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module tipc_top
    import tipc_pkg::*;
#(
    parameter int MID_LOG = PRE_MID_LOG,
    parameter int SLOW_LOG = PRE_SLOW_LOG
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_in,
    output logic [7:0] port_out,
    output logic [7:0] port_oe,
    output logic match_irq,
    output logic capture_irq
);
    tipc_state_t q;
    tipc_state_t d;
    logic tick;
    logic [1:0] valid_edge;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic ev_match;
    logic ev_cap;

    tipc_prescale #(
        .MID_LOG(MID_LOG),
        .SLOW_LOG(SLOW_LOG)
    ) u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sel(q.clk_sel),
        .tick(tick)
    );

    for (genvar i = 0; i < 2; i++)
    begin : g_filt
        tipc_edge_filter u_filt (
            .pclk(pclk),
            .presetn(presetn),
            .ce(ce),
            .tick(tick),
            .pin(port_in[i]),
            .edge_sel(tipc_edge_t'(q.edge_sel[i])),
            .valid_edge(valid_edge[i])
        );
    end

    always_comb
    begin
        hit = 1'b1;
        rd = '0;
        case (paddr)
            OFF_DIR: rd[7:0] = q.dir;
            OFF_MODE: rd[2:0] = {q.restart, q.mode};
            OFF_PRESCALE: rd[7:0] = {q.edge_sel, 2'b00, q.clk_sel};
            OFF_OUTCTL: rd[TOGGLE_EN_BIT] = q.toggle_en;
            OFF_CMP0: rd[15:0] = q.cmp0;
            OFF_CMP1: rd[15:0] = q.cmp1;
            OFF_COUNT: rd[15:0] = q.cnt;
            OFF_STATUS: rd[2:0] = {q.cap_f, q.match_f, q.ovf};
            OFF_MASK: rd[1:0] = q.mask;
            OFF_LATCH: rd[7:0] = q.latch;
            default: hit = 1'b0;
        endcase
    end

    always_comb
    begin
        d = q;
        ev_match = 1'b0;
        ev_cap = 1'b0;
        wr = psel & penable & q.pready & pwrite & hit;
        // One fixed wait-free access phase keeps prdata on a flop
        d.pready = psel & ~penable;
        if (psel & ~penable)
        begin
            d.prdata = pwrite ? 32'h0000_0000 : rd;
            d.pslverr = ~hit;
        end
        if (wr)
        begin
            case (paddr)
                OFF_DIR: d.dir = pwdata[7:0];
                OFF_MODE:
                begin
                    d.mode = tipc_mode_t'(pwdata[1:0]);
                    d.restart = pwdata[MODE_RESTART_BIT];
                end
                OFF_PRESCALE:
                begin
                    d.clk_sel = tipc_clksel_t'(pwdata[1:0]);
                    d.edge_sel[0] = pwdata[EDGE_FIRST_POS +: 2];
                    d.edge_sel[1] = pwdata[EDGE_SECOND_POS +: 2];
                end
                OFF_OUTCTL: d.toggle_en = pwdata[TOGGLE_EN_BIT];
                OFF_CMP0: d.cmp0 = pwdata[15:0];
                OFF_CMP1: d.cmp1 = pwdata[15:0];
                OFF_STATUS:
                begin
                    // Write one to clear; hardware sets below win
                    d.ovf = q.ovf & ~pwdata[STAT_OVF_BIT];
                    d.match_f = q.match_f & ~pwdata[STAT_MATCH_BIT];
                    d.cap_f = q.cap_f & ~pwdata[STAT_CAP_BIT];
                end
                OFF_MASK: d.mask = pwdata[1:0];
                OFF_LATCH: d.latch = pwdata[7:0];
                default: d.mask = q.mask;
            endcase
        end
        d.running = (q.mode != TIPC_STOP);
        if (q.mode == TIPC_STOP)
            d.pulse = 1'b0;
        else if (!q.running)
        begin
            d.cnt = '0;
            d.pulse = (q.mode == TIPC_PPG);
        end
        else
        begin
            if (tick)
            begin
                if (q.cnt == CNT_MAX)
                    d.ovf = 1'b1;
                if (q.mode != TIPC_MEASURE && q.cnt == q.cmp0)
                begin
                    d.cnt = '0;
                    ev_match = 1'b1;
                    if (q.mode == TIPC_PPG)
                        d.pulse = ~q.pulse;
                end
                else
                    d.cnt = CNT_W'(q.cnt + 1'b1);
                if (q.mode == TIPC_PPG && q.cnt == q.cmp1)
                begin
                    ev_cap = 1'b1;
                    if (q.toggle_en)
                        d.pulse = ~d.pulse;
                end
            end
            if (q.mode == TIPC_MEASURE)
            begin
                if (valid_edge[0])
                begin
                    d.cmp1 = q.cnt;
                    ev_cap = 1'b1;
                    if (q.restart)
                        d.cnt = '0;
                end
                if (valid_edge[1])
                begin
                    d.cmp0 = q.cnt;
                    ev_match = 1'b1;
                end
            end
        end
        if (ev_match)
            d.match_f = 1'b1;
        if (ev_cap)
            d.cap_f = 1'b1;
        d.match_irq = ev_match & ~q.mask[0];
        d.cap_irq = ev_cap & ~q.mask[1];
        d.pin_out = q.latch;
        d.pin_out[PIN_PULSE] = q.latch[PIN_PULSE] | q.pulse;
        d.pin_oe = ~q.dir;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= ST_RST;
        else if (ce)
            q <= d;
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign port_out = q.pin_out;
    assign port_oe = q.pin_oe;
    assign match_irq = q.match_irq;
    assign capture_irq = q.cap_irq;

    // Helper flag: low only in the first cycle after reset release
    logic seen_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_q <= 1'b0;
        else
            seen_q <= 1'b1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run_tick;
        ce && q.running && q.mode != TIPC_STOP && tick;
    endsequence

    dir_oe_a: assert property (ce |=> port_oe == ~$past(q.dir))
        else $error("pin enable not inverse of direction");
    dir_reset_a: assert property (!seen_q |-> q.dir == DIR_RST)
        else $error("direction not all ones after reset");
    interval_clear_a: assert property ((s_run_tick and
        q.mode == TIPC_INTERVAL && q.cnt == q.cmp0) |=>
        q.cnt == '0 && q.match_f && match_irq == !$past(q.mask[0]))
        else $error("interval match did not clear and flag");
    ovf_cause_a: assert property ($rose(q.ovf) |->
        $past(q.cnt) == CNT_MAX)
        else $error("overflow without counter at maximum");
    interval_len_a: assert property ($rose(q.match_f) &&
        q.mode == TIPC_INTERVAL |-> $past(q.cnt) == q.cmp0)
        else $error("interval match at wrong count");
    ppg_period_a: assert property ((s_run_tick and q.mode == TIPC_PPG &&
        q.cnt == q.cmp0 && q.cnt != q.cmp1) |=> q.pulse != $past(q.pulse))
        else $error("pulse not inverted at period end");
    width_hold_a: assert property ((s_run_tick and q.mode == TIPC_PPG &&
        !q.toggle_en && q.cnt == q.cmp1 && q.cnt != q.cmp0) |=>
        $stable(q.pulse) ##1 port_out[PIN_PULSE] ==
        ($past(q.latch[PIN_PULSE]) | $past(q.pulse)))
        else $error("pulse toggled with toggling off");
    capture_a: assert property ((ce && q.running &&
        q.mode == TIPC_MEASURE && valid_edge[0]) |=>
        q.cmp1 == $past(q.cnt) && q.cap_f)
        else $error("first edge did not capture count");
    restart_a: assert property ((ce && q.running &&
        q.mode == TIPC_MEASURE && q.restart && valid_edge[0]) |=>
        q.cnt == '0)
        else $error("restart edge did not clear counter");
    advance_a: assert property ((s_run_tick and q.mode == TIPC_MEASURE &&
        !valid_edge[0]) |=> q.cnt == CNT_W'($past(q.cnt) + 1'b1))
        else $error("counter did not advance by one");
endmodule
`default_nettype wire

// ### testbench/timer_interval_ppg_capture_tb.sv
// Purpose: Self-checking bench for the interval/pulse/capture timer.
// Assumes: Short dividers (2 and 4) so prescaled runs stay brief.
// Notes: Edge sources change right after a rising edge, like pclk logic.
`timescale 1ns/100ps
`default_nettype none
module timer_interval_ppg_capture_tb
    import tipc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] port_in;
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic match_irq;
    logic capture_irq;
    logic [1:0] ext = 2'b00;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int m_prev = 0;
    int m_last = 0;
    int cap_n = 0;

    tipc_top #(.MID_LOG(1), .SLOW_LOG(2)) dut (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_in(port_in),
        .port_out(port_out), .port_oe(port_oe), .match_irq(match_irq),
        .capture_irq(capture_irq));
    tipc_pin_model pins (.port_out(port_out), .port_oe(port_oe),
        .ext(ext), .port_in(port_in));

    always #50 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    always @(posedge pclk)
    begin
        if (match_irq === 1'b1)
        begin
            m_prev <= m_last;
            m_last <= cyc;
        end
        if (capture_irq === 1'b1)
            cap_n <= cap_n + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d of %0d checks", err_count, n_checks);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // One APB transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20)
            chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input int w);
        @(posedge pclk);
        ext[0] <= 1'b1;
        repeat (w) @(posedge pclk);
        ext[0] <= 1'b0;
        repeat (10) @(posedge pclk);
    endtask

    task automatic wait_cap(input int k);
        int i;
        i = 0;
        while (cap_n < k && i < 100)
        begin
            @(posedge pclk);
            i++;
        end
    endtask

    task automatic hi_count(output int h);
        h = 0;
        repeat (12)
        begin
            @(posedge pclk);
            if (port_in[PIN_PULSE] === 1'b1)
                h++;
        end
    endtask

    task automatic t_regs();
        apb(1'b0, OFF_DIR, 0);
        chk(rd, 32'h0000_00FF);
        chk({24'h0, port_oe}, 32'h0);
        apb(1'b0, 8'h3C, 0);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, OFF_DIR, 32'hF0);
        repeat (3) @(posedge pclk);
        chk({24'h0, port_oe}, 32'h0F);
        // Driven pins read back the latch, released ones the pull-ups
        apb(1'b1, OFF_LATCH, 32'h05);
        repeat (2) @(posedge pclk);
        chk({24'h0, port_in}, 32'h0000_00F5);
        apb(1'b1, OFF_LATCH, 0);
    endtask

    task automatic t_interval();
        int m;
        apb(1'b1, OFF_CMP0, 3);
        apb(1'b1, OFF_PRESCALE, 0);
        apb(1'b1, OFF_MODE, 1);
        repeat (20) @(posedge pclk);
        chk(m_last - m_prev, 4);
        apb(1'b0, OFF_STATUS, 0);
        chk(rd, 32'h2);
        // Prescale may only change while stopped
        apb(1'b1, OFF_MODE, 0);
        apb(1'b1, OFF_PRESCALE, 1);
        apb(1'b1, OFF_MODE, 1);
        repeat (40) @(posedge pclk);
        chk(m_last - m_prev, 8);
        apb(1'b1, OFF_MASK, 1);
        // A match in the write cycle still used the old mask
        repeat (2) @(posedge pclk);
        m = m_last;
        repeat (20) @(posedge pclk);
        chk(m_last, m);
        apb(1'b1, OFF_MODE, 0);
        apb(1'b1, OFF_MASK, 0);
        apb(1'b1, OFF_STATUS, 7);
    endtask

    task automatic t_ppg();
        int h;
        apb(1'b1, OFF_DIR, 32'hF1);
        apb(1'b1, OFF_LATCH, 0);
        apb(1'b1, OFF_CMP0, 5);
        apb(1'b1, OFF_CMP1, 1);
        apb(1'b1, OFF_OUTCTL, 32'h10);
        apb(1'b1, OFF_PRESCALE, 0);
        apb(1'b1, OFF_MODE, 3);
        repeat (10) @(posedge pclk);
        hi_count(h);
        chk(h, 4);
        // Without width toggling only the period match inverts
        apb(1'b1, OFF_OUTCTL, 0);
        repeat (6) @(posedge pclk);
        hi_count(h);
        chk(h, 6);
        // Safe width change while running; either phase gives half high
        apb(1'b1, OFF_MASK, 2);
        apb(1'b1, OFF_CMP1, 2);
        repeat (2) @(posedge pclk);
        apb(1'b1, OFF_OUTCTL, 32'h10);
        apb(1'b1, OFF_STATUS, 4);
        apb(1'b1, OFF_MASK, 0);
        repeat (6) @(posedge pclk);
        hi_count(h);
        chk(h, 6);
        apb(1'b1, OFF_MODE, 0);
    endtask

    task automatic t_edges();
        int n;
        logic [31:0] c1;
        int exp_n [4] = '{1, 1, 0, 2};
        apb(1'b1, OFF_DIR, 32'hF3);
        for (int c = 0; c < 4; c++)
        begin
            apb(1'b1, OFF_MODE, 0);
            apb(1'b1, OFF_PRESCALE, c << EDGE_FIRST_POS);
            apb(1'b1, OFF_MODE, 2);
            n = cap_n;
            pulse(10);
            chk(cap_n - n, exp_n[c]);
        end
        n = cap_n;
        pulse(1);
        chk(cap_n - n, 0);
        pulse(2);
        chk(cap_n - n, 2);
        n = cap_n;
        fork
            pulse(30);
            begin
                wait_cap(n + 1);
                apb(1'b0, OFF_CMP1, 0);
                c1 = rd;
                wait_cap(n + 2);
                apb(1'b0, OFF_CMP1, 0);
            end
        join
        chk(rd - c1, 30);
        apb(1'b0, OFF_STATUS, 0);
        chk(rd & 32'h4, 32'h4);
        apb(1'b1, OFF_STATUS, 7);
        apb(1'b0, OFF_STATUS, 0);
        chk(rd, 32'h0);
        // Frozen cycles must not count: only the first setup, the first access and the idle cycle before the next setup advance
        apb(1'b0, OFF_COUNT, 0);
        c1 = rd;
        ce <= 1'b0;
        repeat (20) @(posedge pclk);
        ce <= 1'b1;
        apb(1'b0, OFF_COUNT, 0);
        chk(rd - c1, 3);
        // Restart on rising edges: 31 cycles between rises read as 30
        apb(1'b1, OFF_MODE, 0);
        apb(1'b1, OFF_PRESCALE, 32'h10);
        apb(1'b1, OFF_MODE, 6);
        pulse(20);
        pulse(20);
        apb(1'b0, OFF_CMP1, 0);
        chk(rd, 30);
        apb(1'b1, OFF_MODE, 0);
    endtask

    initial
    begin
        #3000000;
        err_count++;
        $display("ERROR %0t: timeout", $time);
        stop_test();
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_interval();
        t_ppg();
        t_edges();
        stop_test();
    end
endmodule
`default_nettype wire

// ### testbench/tipc_pin_model.sv
// Purpose: Pin-level model of the pulse sources and the output load.
// Assumes: Pins 2 to 7 have pull-ups; pins 0 and 1 see the bench sources.
// Notes: A driven pin reads back its own output, so the load never fights.
`timescale 1ns/100ps
`default_nettype none
module tipc_pin_model (
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe,
    input wire logic [1:0] ext,
    output logic [7:0] port_in
);
    logic [7:0] far;
    assign far = {6'h3F, ext};
    // Released pins follow the source or the pull-up
    assign port_in = (port_oe & port_out) | (~port_oe & far);
endmodule
`default_nettype wire
